// File: hw/edo_ctrl_pkg.sv
package edo_ctrl_pkg;

    // clock rate
    localparam int CLK_PERIOD_PS = 40000;

    // geometry
    localparam int ADDR_PINS  = 10;
    localparam int DATA_WIDTH = 16;
    localparam int WORD_ADDR  = 20;

    // device timing figures in ns, us or ms as printed (fast grade)
    localparam int ROW_ACTIVE_WIDTH_MIN_NS  = 60;
    localparam int ROW_ACTIVE_WIDTH_MAX_NS  = 10000;
    localparam int RANDOM_CYCLE_TIME_NS     = 105;
    localparam int ROW_TO_COLUMN_DELAY_NS   = 14;
    localparam int ROW_ADDR_HOLD_NS         = 10;
    localparam int ENABLE_TO_DATA_TIME_NS   = 15;
    localparam int OUTPUT_RELEASE_DELAY_NS  = 15;
    localparam int ROW_PRECHARGE_NS         = 40;
    localparam int COLUMN_ACCESS_NS         = 15;
    localparam int COLUMN_SETUP_REFRESH_NS  = 5;
    localparam int POWERUP_PAUSE_US         = 100;
    localparam int REFRESH_PERIOD_MS        = 16;
    localparam int REFRESH_ROWS             = 1024;
    localparam int WARMUP_REFRESHES         = 8;

    // least times round up to whole cycles, never below one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min

    // longest times round down
    function automatic int cyc_max(input int ns);
        int c;
        c = (ns * 1000) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_max

    localparam int ROW_ACTIVE_CYC   = cyc_min(ROW_ACTIVE_WIDTH_MIN_NS);
    localparam int ROW_ACTIVE_MAX_CYC = cyc_max(ROW_ACTIVE_WIDTH_MAX_NS);
    localparam int CYCLE_TIME_CYC   = cyc_min(RANDOM_CYCLE_TIME_NS);
    localparam int ROW_TO_COL_CYC   = cyc_min(ROW_TO_COLUMN_DELAY_NS);
    localparam int ROW_HOLD_CYC     = cyc_min(ROW_ADDR_HOLD_NS);
    localparam int OE_TO_DATA_CYC   = cyc_min(ENABLE_TO_DATA_TIME_NS);
    localparam int COL_ACCESS_CYC   = cyc_min(COLUMN_ACCESS_NS);
    localparam int RELEASE_CYC      = cyc_min(OUTPUT_RELEASE_DELAY_NS);
    localparam int PRECHARGE_CYC    = cyc_min(ROW_PRECHARGE_NS);
    localparam int CBR_SETUP_CYC    = cyc_min(COLUMN_SETUP_REFRESH_NS);
    localparam int POWERUP_CYC      = POWERUP_PAUSE_US * 1000 * 1000
                                      / CLK_PERIOD_PS;
    localparam int REFRESH_GAP_CYC  = REFRESH_PERIOD_MS * 1000 * 1000
                                      / (CLK_PERIOD_PS / 1000)
                                      / REFRESH_ROWS;

    // host request kinds
    typedef enum logic [1:0] {
        req_read,
        req_write,
        req_rmw
    } req_kind_type;

endpackage : edo_ctrl_pkg

// File: hw/edo_cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none

// down counter loaded with a cycle count, flags when it reaches zero
module edo_cycle_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic                  expired
);

    logic [WIDTH-1:0] count_reg;

    // load wins over counting
    always_ff @(posedge clk)
    begin
        if (reset)
            count_reg <= '0;
        else if (clk_en)
        begin
            if (load)
                count_reg <= load_value;
            else if (count_reg != '0)
                count_reg <= count_reg - 1'b1;
        end
    end

    assign expired = (count_reg == '0);

endmodule : edo_cycle_timer

`default_nettype wire

// File: hw/edo_dram_interface.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - column strobe before row with write high refreshes; data stays open
// - row strobe low at least 60 ns and at most 10,000 ns
// - random accesses start no more than once per 105 ns
// - early write: write strobe low before column strobe, with data valid
// - row address set before row strobe falls, held 10 ns after
// - column strobe 14 ns to 45 ns after the row strobe
// - wait 100 us after power-up, then eight refreshes before use
// - write timing picks early write or read-modify-write
module edo_dram_interface #(
    parameter int POWERUP_CYCLES = edo_ctrl_pkg::POWERUP_CYC,
    parameter int REFRESH_GAP    = edo_ctrl_pkg::REFRESH_GAP_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [1:0]  req_kind,
    input  wire logic [19:0] req_addr,
    input  wire logic [15:0] req_wdata,
    input  wire logic [1:0]  req_byte_en,
    output logic             rsp_valid,
    output logic [15:0]      rsp_rdata,
    output logic             init_done,
    output logic             row_strobe_pin,
    output logic             lower_byte_column_strobe,
    output logic             upper_byte_column_strobe,
    output logic             write_strobe_input,
    output logic             output_enable_n,
    output logic [9:0]       mux_address_bus,
    input  wire logic [15:0] data_lines_in,
    output logic [15:0]      data_lines_out,
    output logic             data_lines_oe
);

    typedef enum logic [3:0] {
        st_powerup,
        st_idle,
        st_row,
        st_col,
        st_data,
        st_write_late,
        st_finish,
        st_cbr_setup,
        st_cbr_row,
        st_precharge
    } state_type;

    state_type        state_reg;
    logic [1:0]       kind_reg;
    logic [9:0]       col_reg;
    logic [1:0]       ben_reg;
    logic [15:0]      wdata_reg;
    logic [3:0]       warm_reg;
    logic [15:0]      step_reg;
    logic [31:0]      refresh_cnt_reg;
    logic             refresh_due_reg;
    logic             pause_armed_reg;
    logic             timer_load;
    logic [31:0]      timer_value;
    logic             timer_done;

    localparam logic [15:0] ROW_CYC  = 16'(edo_ctrl_pkg::ROW_ACTIVE_CYC);
    localparam logic [15:0] RCD_CYC  = 16'(edo_ctrl_pkg::ROW_TO_COL_CYC);
    localparam logic [15:0] CAS_CYC  = 16'(edo_ctrl_pkg::COL_ACCESS_CYC);
    localparam logic [15:0] OE_CYC   = 16'(edo_ctrl_pkg::OE_TO_DATA_CYC);
    localparam logic [15:0] PRE_CYC  = 16'(edo_ctrl_pkg::PRECHARGE_CYC);
    localparam logic [15:0] REL_CYC  = 16'(edo_ctrl_pkg::RELEASE_CYC);
    localparam logic [15:0] CBRS_CYC = 16'(edo_ctrl_pkg::CBR_SETUP_CYC);
    localparam logic [15:0] TRC_CYC  = 16'(edo_ctrl_pkg::CYCLE_TIME_CYC);
    localparam logic [15:0] ROW_HOLD = 16'(edo_ctrl_pkg::ROW_HOLD_CYC);

    // long power-up pause timer
    edo_cycle_timer #(
        .WIDTH(32)
    ) u_pause (
        .clk       (clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .load      (timer_load),
        .load_value(timer_value),
        .expired   (timer_done)
    );

    // pause timer loads once, on the first enabled cycle after reset
    assign timer_load  = !pause_armed_reg;
    assign timer_value = 32'(POWERUP_CYCLES);

    // marks that the power-up pause has been loaded
    always_ff @(posedge clk)
    begin
        if (reset)
            pause_armed_reg <= 1'b0;
        else if (clk_en)
            pause_armed_reg <= 1'b1;
    end

    // periodic refresh request, set wins over the clear
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            refresh_cnt_reg <= 32'h00000000;
            refresh_due_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (refresh_cnt_reg >= 32'(REFRESH_GAP - 1))
            begin
                refresh_cnt_reg <= 32'h00000000;
                refresh_due_reg <= 1'b1;
            end
            else
            begin
                refresh_cnt_reg <= refresh_cnt_reg + 32'h00000001;
                if (state_reg == st_cbr_row)
                    refresh_due_reg <= 1'b0;
            end
        end
    end

    assign req_ready = (state_reg == st_idle) && init_done && !refresh_due_reg;

    // access and refresh sequencer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= st_powerup;
            step_reg  <= 16'h0000;
            warm_reg  <= 4'h0;
            init_done <= 1'b0;
            kind_reg  <= 2'h0;
            col_reg   <= 10'h000;
            ben_reg   <= 2'h0;
            wdata_reg <= 16'h0000;
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            row_strobe_pin           <= 1'b1;
            lower_byte_column_strobe <= 1'b1;
            upper_byte_column_strobe <= 1'b1;
            write_strobe_input       <= 1'b1;
            output_enable_n          <= 1'b1;
            mux_address_bus          <= 10'h000;
            data_lines_out           <= 16'h0000;
            data_lines_oe            <= 1'b0;
        end
        else if (clk_en)
        begin
            rsp_valid <= 1'b0;
            if (step_reg != 16'h0000)
                step_reg <= step_reg - 16'h0001;
            unique case (state_reg)
                st_powerup:
                    if (pause_armed_reg && timer_done)
                    begin
                        state_reg <= st_cbr_setup;
                        step_reg  <= CBRS_CYC;
                        lower_byte_column_strobe <= 1'b0;
                        upper_byte_column_strobe <= 1'b0;
                    end
                st_idle:
                    if (init_done && refresh_due_reg)
                    begin
                        state_reg <= st_cbr_setup;
                        step_reg  <= CBRS_CYC;
                        write_strobe_input <= 1'b1;
                        lower_byte_column_strobe <= 1'b0;
                        upper_byte_column_strobe <= 1'b0;
                    end
                    else if (req_valid && req_ready)
                    begin
                        kind_reg  <= req_kind;
                        col_reg   <= req_addr[9:0];
                        ben_reg   <= req_byte_en;
                        wdata_reg <= req_wdata;
                        mux_address_bus <= req_addr[19:10];
                        state_reg <= st_row;
                        step_reg  <= 16'h0000;
                    end
                st_row:
                begin
                    // row address already stable a cycle before the fall
                    row_strobe_pin <= 1'b0;
                    if (kind_reg == edo_ctrl_pkg::req_write)
                    begin
                        write_strobe_input <= 1'b0;
                        data_lines_out     <= wdata_reg;
                        data_lines_oe      <= 1'b1;
                    end
                    state_reg <= st_col;
                    step_reg  <= (RCD_CYC > ROW_HOLD) ? RCD_CYC : ROW_HOLD;
                end
                st_col:
                    if (step_reg <= 16'h0001)
                    begin
                        mux_address_bus <= col_reg;
                        lower_byte_column_strobe <= !ben_reg[0];
                        upper_byte_column_strobe <= !ben_reg[1];
                        if (kind_reg != edo_ctrl_pkg::req_write)
                            output_enable_n <= 1'b0;
                        state_reg <= st_data;
                        step_reg  <= (CAS_CYC > OE_CYC) ? CAS_CYC : OE_CYC;
                    end
                st_data:
                    if (step_reg <= 16'h0001)
                    begin
                        if (kind_reg != edo_ctrl_pkg::req_write)
                        begin
                            rsp_rdata <= data_lines_in;
                            rsp_valid <= 1'b1;
                        end
                        if (kind_reg == edo_ctrl_pkg::req_rmw)
                        begin
                            // late write after data read
                            output_enable_n    <= 1'b1;
                            state_reg          <= st_write_late;
                            step_reg           <= REL_CYC;
                        end
                        else
                        begin
                            state_reg <= st_finish;
                            step_reg  <= ROW_CYC - RCD_CYC - CAS_CYC;
                        end
                    end
                st_write_late:
                    if (step_reg <= 16'h0001)
                    begin
                        write_strobe_input <= 1'b0;
                        data_lines_out     <= wdata_reg;
                        data_lines_oe      <= 1'b1;
                        state_reg <= st_finish;
                        step_reg  <= REL_CYC;
                    end
                st_finish:
                    if (step_reg <= 16'h0001)
                    begin
                        // row held low at least the minimum width
                        row_strobe_pin           <= 1'b1;
                        lower_byte_column_strobe <= 1'b1;
                        upper_byte_column_strobe <= 1'b1;
                        write_strobe_input       <= 1'b1;
                        output_enable_n          <= 1'b1;
                        data_lines_oe            <= 1'b0;
                        state_reg <= st_precharge;
                        // precharge also pads the whole cycle out to RANDOM_CYCLE_TIME
                        step_reg  <= (PRE_CYC > TRC_CYC - ROW_CYC)
                                     ? PRE_CYC : TRC_CYC - ROW_CYC;
                    end
                st_cbr_setup:
                    if (step_reg <= 16'h0001)
                    begin
                        row_strobe_pin <= 1'b0;
                        state_reg <= st_cbr_row;
                        step_reg  <= ROW_CYC;
                    end
                st_cbr_row:
                    if (step_reg <= 16'h0001)
                    begin
                        row_strobe_pin           <= 1'b1;
                        lower_byte_column_strobe <= 1'b1;
                        upper_byte_column_strobe <= 1'b1;
                        if (!init_done)
                            warm_reg <= warm_reg + 4'h1;
                        state_reg <= st_precharge;
                        step_reg  <= (PRE_CYC > TRC_CYC - ROW_CYC)
                                     ? PRE_CYC : TRC_CYC - ROW_CYC;
                    end
                st_precharge:
                    if (step_reg <= 16'h0001)
                    begin
                        if (!init_done &&
                            warm_reg < 4'(edo_ctrl_pkg::WARMUP_REFRESHES))
                        begin
                            state_reg <= st_cbr_setup;
                            step_reg  <= CBRS_CYC;
                            lower_byte_column_strobe <= 1'b0;
                            upper_byte_column_strobe <= 1'b0;
                        end
                        else
                        begin
                            init_done <= 1'b1;
                            state_reg <= st_idle;
                        end
                    end
            endcase
        end
    end

endmodule : edo_dram_interface

`default_nettype wire

// File: tb/edo_dram_interface_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// strobe and handshake checks on the controller's ports
module edo_dram_interface_assertions #(
    parameter int POWERUP_CYCLES = 20,
    parameter int REFRESH_GAP    = 60
) (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       clk_en,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic [1:0] req_kind,
    input wire logic       rsp_valid,
    input wire logic       init_done,
    input wire logic       row_strobe_pin,
    input wire logic       lower_byte_column_strobe,
    input wire logic       upper_byte_column_strobe,
    input wire logic       write_strobe_input,
    input wire logic       output_enable_n,
    input wire logic [9:0] mux_address_bus,
    input wire logic       data_lines_oe
);
    logic        row_prev_reg;
    logic [15:0] low_cnt_reg;
    logic [15:0] pwr_cnt_reg;
    logic [3:0]  ref_cnt_reg;
    logic [15:0] gap_cnt_reg;
    logic        cbr_fall;
    logic        col_high;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // refresh start: row falls with a column strobe already low
    assign col_high = lower_byte_column_strobe && upper_byte_column_strobe;
    assign cbr_fall = row_prev_reg && !row_strobe_pin && !col_high;

    // previous row level
    always_ff @(posedge clk)
        row_prev_reg <= reset ? 1'h1 : row_strobe_pin;

    // length of the current row-low stretch
    always_ff @(posedge clk)
        low_cnt_reg <= (reset || row_strobe_pin) ? 16'h0000 : low_cnt_reg + 1;

    // cycles since reset, saturating
    always_ff @(posedge clk)
        if (reset)
            pwr_cnt_reg <= 16'h0000;
        else if (pwr_cnt_reg != 16'hFFFF)
            pwr_cnt_reg <= pwr_cnt_reg + 1;

    // refreshes since reset and cycles since the last one
    always_ff @(posedge clk)
        if (reset)
            ref_cnt_reg <= 4'h0;
        else if (cbr_fall && ref_cnt_reg != 4'hF)
            ref_cnt_reg <= ref_cnt_reg + 1;

    always_ff @(posedge clk)
        if (reset || cbr_fall)
            gap_cnt_reg <= 16'h0000;
        else if (init_done && clk_en)
            gap_cnt_reg <= gap_cnt_reg + 1;

    // row address unchanged across the row fall; any later change is
    // at least one clock period after it
    sequence addr_held;
        $stable(mux_address_bus);
    endsequence

    a_row_min_width: assert property ($fell(row_strobe_pin) |->
        (!row_strobe_pin) [*2]) else $error("row strobe pulse too short");
    a_row_max_width: assert property (!row_strobe_pin |->
        low_cnt_reg < edo_ctrl_pkg::ROW_ACTIVE_MAX_CYC)
        else $error("row strobe held low too long");
    a_cycle_spacing: assert property ($fell(row_strobe_pin) |=>
        (!$fell(row_strobe_pin)) [*2]) else $error("row cycles too close");
    a_row_addr_hold: assert property ($fell(row_strobe_pin) && col_high |->
        addr_held) else $error("row address not held");
    a_col_after_row: assert property ($fell(row_strobe_pin) && col_high |->
        ##1 $fell(col_high)) else $error("column strobe not in window");
    a_refresh_quiet: assert property (cbr_fall |->
        write_strobe_input && !data_lines_oe)
        else $error("refresh with write low or data driven");
    a_early_write: assert property ($fell(col_high) && !write_strobe_input |->
        $past(write_strobe_input) == 1'h0 && data_lines_oe)
        else $error("early write not set up before column");
    a_write_data: assert property ($fell(write_strobe_input) |->
        data_lines_oe) else $error("write strobe without data");
    a_init_gate: assert property (!init_done |-> !req_ready)
        else $error("request accepted before init");
    a_init_count: assert property ($rose(init_done) |->
        ref_cnt_reg >= 4'h8 && pwr_cnt_reg >= POWERUP_CYCLES)
        else $error("init finished early");
    a_read_answer: assert property (req_valid && req_ready
        && req_kind != 2'h1 |-> ##[3:8] rsp_valid)
        else $error("read answer missing");
    a_refresh_gap: assert property (init_done |->
        gap_cnt_reg <= REFRESH_GAP + 20) else $error("refresh overdue");
endmodule : edo_dram_interface_assertions

bind edo_dram_interface edo_dram_interface_assertions #(
    .POWERUP_CYCLES(POWERUP_CYCLES), .REFRESH_GAP(REFRESH_GAP)
) chk (.clk, .reset, .clk_en, .req_valid, .req_ready, .req_kind, .rsp_valid,
    .init_done, .row_strobe_pin, .lower_byte_column_strobe,
    .upper_byte_column_strobe, .write_strobe_input, .output_enable_n,
    .mux_address_bus, .data_lines_oe);

`default_nettype wire

// File: tb/edo_dram_interface_bench.sv
`timescale 1ns/1ps
`default_nettype none

`define check_eq(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    err_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

module edo_dram_interface_bench;
    logic        clk, reset, clk_en, req_valid, req_ready, rsp_valid;
    logic        init_done, row_s, low_s, upp_s, wr_s, oe_n, d_oe;
    logic [1:0]  req_kind, req_byte_en;
    logic [19:0] req_addr;
    logic [15:0] req_wdata, rsp_rdata, d_in, d_out, d_bus;
    logic [9:0]  addr_bus;
    int          refresh_count, err_count = 0, checks = 0, cycles = 0;

    edo_dram_interface #(.POWERUP_CYCLES(20), .REFRESH_GAP(60)) DUT (
        .clk, .reset, .clk_en, .req_valid, .req_ready, .req_kind,
        .req_addr, .req_wdata, .req_byte_en, .rsp_valid, .rsp_rdata,
        .init_done, .row_strobe_pin(row_s), .lower_byte_column_strobe(low_s),
        .upper_byte_column_strobe(upp_s), .write_strobe_input(wr_s),
        .output_enable_n(oe_n), .mux_address_bus(addr_bus),
        .data_lines_in(d_in), .data_lines_out(d_out), .data_lines_oe(d_oe));

    // released data lines read back inverted at the memory
    assign d_bus = d_oe ? d_out : ~d_out;

    edo_mem_model far_mem (.row_strobe_pin(row_s),
        .lower_byte_column_strobe(low_s), .upper_byte_column_strobe(upp_s),
        .write_strobe_input(wr_s), .output_enable_n(oe_n),
        .mux_address_bus(addr_bus), .data_in(d_bus), .data_out(d_in),
        .refresh_count);

    // clock and hang limit
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_count++;
            close_out();
        end
    end

    task automatic close_out;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // one request; read kinds wait for the answer
    task automatic xfer(input logic [1:0] k, input logic [19:0] a,
                        input logic [15:0] d, input logic [1:0] be,
                        output logic [15:0] q);
        int n;
        n = 0;
        while (req_ready !== 1'h1 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        req_valid = 1'h1;
        req_kind = k;
        req_addr = a;
        req_wdata = d;
        req_byte_en = be;
        @(negedge clk);
        req_valid = 1'h0;
        q = 16'hXXXX;
        n = 0;
        while (k != 2'h1 && rsp_valid !== 1'h1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        if (k != 2'h1)
            q = rsp_rdata;
    endtask : xfer

    task automatic t_init;
        int n;
        n = 0;
        while (init_done !== 1'h1 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        `check_eq("init_done", 1'h1, init_done)
        `check_eq("warmup refreshes", 8, refresh_count)
        $display("test init done");
    endtask : t_init

    // corners of the row and column fields, written then read back
    task automatic t_rows;
        logic [19:0] a [4] = '{20'h00001, 20'h00400, 20'hFFC00, 20'h003FF};
        logic [15:0] q;
        for (int i = 0; i < 4; i++)
            xfer(edo_ctrl_pkg::req_write, a[i], 16'hA000 + 16'(i), 2'h3, q);
        for (int i = 0; i < 4; i++)
        begin
            xfer(edo_ctrl_pkg::req_read, a[i], 16'h0000, 2'h3, q);
            `check_eq("row col word", 16'hA000 + 16'(i), q)
        end
        $display("test rows done");
    endtask : t_rows

    // byte enables gate the two column strobes
    task automatic t_bytes;
        logic [15:0] q;
        xfer(edo_ctrl_pkg::req_write, 20'h12345, 16'h1234, 2'h3, q);
        xfer(edo_ctrl_pkg::req_write, 20'h12345, 16'hABCD, 2'h1, q);
        xfer(edo_ctrl_pkg::req_write, 20'h12345, 16'h5600, 2'h2, q);
        xfer(edo_ctrl_pkg::req_read, 20'h12345, 16'h0000, 2'h3, q);
        `check_eq("byte lanes", 16'h56CD, q)
        $display("test bytes done");
    endtask : t_bytes

    // read-modify-write returns old data and stores new
    task automatic t_rmw;
        logic [15:0] q;
        xfer(edo_ctrl_pkg::req_rmw, 20'h12345, 16'h7777, 2'h3, q);
        `check_eq("rmw old data", 16'h56CD, q)
        xfer(edo_ctrl_pkg::req_read, 20'h12345, 16'h0000, 2'h3, q);
        `check_eq("rmw new data", 16'h7777, q)
        $display("test rmw done");
    endtask : t_rmw

    // idle refresh rate, data kept across refreshes
    task automatic t_refresh;
        int          base;
        logic [15:0] q;
        base = refresh_count;
        repeat (300) @(negedge clk);
        `check_eq("refresh rate", 1'h1, (refresh_count - base) inside {[4:6]})
        base = refresh_count;
        clk_en = 1'h0;
        repeat (70) @(negedge clk);
        `check_eq("frozen refresh", base, refresh_count)
        clk_en = 1'h1;
        xfer(edo_ctrl_pkg::req_read, 20'h12345, 16'h0000, 2'h3, q);
        `check_eq("kept data", 16'h7777, q)
        $display("test refresh done");
    endtask : t_refresh

    // main sequence
    initial
    begin
        reset = 1'h1;
        clk_en = 1'h1;
        req_valid = 1'h0;
        req_kind = 2'h0;
        req_addr = 20'h00000;
        req_wdata = 16'h0000;
        req_byte_en = 2'h3;
        repeat (5) @(negedge clk);
        reset = 1'h0;
        t_init();
        t_rows();
        t_bytes();
        t_rmw();
        t_refresh();
        close_out();
    end
endmodule : edo_dram_interface_bench

`default_nettype wire

// File: tb/edo_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// behavioural word memory standing on the far side of the strobes
module edo_mem_model (
    input  wire logic        row_strobe_pin,
    input  wire logic        lower_byte_column_strobe,
    input  wire logic        upper_byte_column_strobe,
    input  wire logic        write_strobe_input,
    input  wire logic        output_enable_n,
    input  wire logic [9:0]  mux_address_bus,
    input  wire logic [15:0] data_in,
    output var logic  [15:0] data_out,
    output var int           refresh_count
);
    logic [7:0]  lo_mem [int];
    logic [7:0]  hi_mem [int];
    logic [9:0]  row_reg = 10'h000;
    logic [9:0]  col_reg = 10'h000;
    logic        cbr_reg = 1'h0;
    logic [15:0] last_reg = 16'h0000;

    initial refresh_count = 0;

    // stored word at the latched row and column, unwritten bytes as zero
    function automatic logic [15:0] word_at();
        int a;
        a = int'({row_reg, col_reg});
        return {hi_mem.exists(a) ? hi_mem[a] : 8'h00,
                lo_mem.exists(a) ? lo_mem[a] : 8'h00};
    endfunction : word_at

    // row fall latches the row and counts a column-first refresh
    always @(negedge row_strobe_pin)
    begin
        cbr_reg = !(lower_byte_column_strobe && upper_byte_column_strobe);
        row_reg = mux_address_bus;
        if (cbr_reg && write_strobe_input)
            refresh_count++;
    end

    // column falls latch the column; early write stores its lane
    always @(negedge lower_byte_column_strobe)
    begin
        #1;
        col_reg = mux_address_bus;
        if (!row_strobe_pin && !cbr_reg && !write_strobe_input)
            lo_mem[int'({row_reg, col_reg})] = data_in[7:0];
    end

    always @(negedge upper_byte_column_strobe)
    begin
        #1;
        col_reg = mux_address_bus;
        if (!row_strobe_pin && !cbr_reg && !write_strobe_input)
            hi_mem[int'({row_reg, col_reg})] = data_in[15:8];
    end

    // late write after the read part of a read-modify-write
    always @(negedge write_strobe_input)
    begin
        #1;
        if (!row_strobe_pin && !cbr_reg && !lower_byte_column_strobe)
            lo_mem[int'({row_reg, col_reg})] = data_in[7:0];
        if (!row_strobe_pin && !cbr_reg && !upper_byte_column_strobe)
            hi_mem[int'({row_reg, col_reg})] = data_in[15:8];
    end

    // drive data on a read, otherwise an inverted stale pattern
    always @(row_strobe_pin or lower_byte_column_strobe
             or upper_byte_column_strobe or write_strobe_input
             or output_enable_n or cbr_reg or row_reg or col_reg)
    begin
        if (!row_strobe_pin && !cbr_reg && write_strobe_input
            && !output_enable_n
            && !(lower_byte_column_strobe && upper_byte_column_strobe))
        begin
            data_out = word_at();
            last_reg = data_out;
        end
        else
            data_out = ~last_reg;
    end
endmodule : edo_mem_model

`default_nettype wire
